/* rtl/irq_flag_defs.vh */
`ifndef IRQ_FLAG_DEFS_VH
`define IRQ_FLAG_DEFS_VH
`define ADDR_MEM_FLAGS   8'h8D
`define ADDR_TMR_FLAGS   8'h8E
`define ADDR_PWM_FLAGS   8'h8F
`define ADDR_SER_FLAGS   8'h90
`define ADDR_IRQ_STATUS  8'hA0
`define ADDR_IRQ_MASK    8'hA1
`define MEM_FLAGS_MASK   8'h03
`define TMR_FLAGS_MASK   8'h6F
`define PWM_FLAGS_MASK   8'h0F
`define SER_FLAGS_MASK   8'h3F
`define SER_RX_BIT       7
`define SER_TX_BIT       6
`define FLAGS_RESET      8'h00
`define IRQ_GRP_RESET    4'h0
`endif

/* rtl/peripheral_irq_flag_regs.v */
`timescale 1ns/1ps
`include "irq_flag_defs.vh"
module peripheral_irq_flag_regs (
  input  wire       core_clk_i,
  input  wire       rst_n_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       checksum_evt_i,
  input  wire       memory_op_done_evt_i,
  input  wire       capcmp_unit2_evt_i,
  input  wire       capcmp_unit1_evt_i,
  input  wire       timer_four_evt_i,
  input  wire       timer_two_evt_i,
  input  wire       timer_three_gate_active_i,
  input  wire       timer_three_evt_i,
  input  wire       pulse_unit2_param_evt_i,
  input  wire       pulse_unit2_period_evt_i,
  input  wire       pulse_unit1_param_evt_i,
  input  wire       pulse_unit1_period_evt_i,
  input  wire       serial1_rx_not_empty_i,
  input  wire       serial1_tx_empty_i,
  input  wire [3:0] logic_cell_evt_i,
  input  wire       waveform_gen_evt_i,
  input  wire       oscillator_unit_evt_i,
  output wire       irq_o
);
  wire [7:0] mem_flags;
  wire [7:0] tmr_flags;
  wire [7:0] pwm_flags;
  wire [7:0] ser_flags;
  wire [3:0] grp_rise;
  reg        gate_act_ff;
  reg  [3:0] irq_status_ff;
  reg  [3:0] irq_mask_ff;
  reg  [3:0] nxt_irq_status;
  wire [7:0] mem_set;
  wire [7:0] tmr_set;
  wire [7:0] pwm_set;
  wire [7:0] ser_set;
  wire       gate_fall;
  wire       wr_mem;
  wire       wr_tmr;
  wire       wr_pwm;
  wire       wr_ser;

  // gate level comes from the timer logic on this clock; a fall marks inactive
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      gate_act_ff <= 1'b0;
    end else begin
      gate_act_ff <= timer_three_gate_active_i;
    end
  end
  assign gate_fall = gate_act_ff & ~timer_three_gate_active_i;

  assign mem_set = {6'h00, checksum_evt_i, memory_op_done_evt_i};
  // capture unit events already reflect the unit's own mode selection
  assign tmr_set = {1'b0, capcmp_unit2_evt_i, capcmp_unit1_evt_i, 1'b0,
                    timer_four_evt_i, timer_two_evt_i,
                    gate_fall, timer_three_evt_i};
  assign pwm_set = {4'h0, pulse_unit2_param_evt_i, pulse_unit2_period_evt_i,
                    pulse_unit1_param_evt_i, pulse_unit1_period_evt_i};
  assign ser_set = {2'h0, logic_cell_evt_i,
                    waveform_gen_evt_i, oscillator_unit_evt_i};

  assign wr_mem = wr_i && (addr_i == `ADDR_MEM_FLAGS);
  assign wr_tmr = wr_i && (addr_i == `ADDR_TMR_FLAGS);
  assign wr_pwm = wr_i && (addr_i == `ADDR_PWM_FLAGS);
  assign wr_ser = wr_i && (addr_i == `ADDR_SER_FLAGS);

  sticky_flag_bank #(.IMPL_MASK(`MEM_FLAGS_MASK)) u_mem_bank (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .set_i      (mem_set),
    .wr_i       (wr_mem),
    .wdata_i    (wdata_i),
    .flags_o    (mem_flags),
    .rise_o     (grp_rise[0])
  );
  sticky_flag_bank #(.IMPL_MASK(`TMR_FLAGS_MASK)) u_tmr_bank (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .set_i      (tmr_set),
    .wr_i       (wr_tmr),
    .wdata_i    (wdata_i),
    .flags_o    (tmr_flags),
    .rise_o     (grp_rise[1])
  );
  sticky_flag_bank #(.IMPL_MASK(`PWM_FLAGS_MASK)) u_pwm_bank (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .set_i      (pwm_set),
    .wr_i       (wr_pwm),
    .wdata_i    (wdata_i),
    .flags_o    (pwm_flags),
    .rise_o     (grp_rise[2])
  );
  // upper two bits are never stored: the serial unit owns them
  sticky_flag_bank #(.IMPL_MASK(`SER_FLAGS_MASK)) u_ser_bank (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .set_i      (ser_set),
    .wr_i       (wr_ser),
    .wdata_i    (wdata_i),
    .flags_o    (ser_flags),
    .rise_o     (grp_rise[3])
  );

  // per-group sticky event status, write one to clear; set beats clear
  always @* begin
    nxt_irq_status = irq_status_ff;
    if (wr_i && (addr_i == `ADDR_IRQ_STATUS)) begin
      nxt_irq_status = nxt_irq_status & ~wdata_i[3:0];
    end
    nxt_irq_status = nxt_irq_status | grp_rise;
  end
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_status_ff <= `IRQ_GRP_RESET;
      irq_mask_ff   <= `IRQ_GRP_RESET;
    end else begin
      irq_status_ff <= nxt_irq_status;
      if (wr_i && (addr_i == `ADDR_IRQ_MASK)) begin
        irq_mask_ff <= wdata_i[3:0];
      end
    end
  end
  assign irq_o = |(irq_status_ff & irq_mask_ff);

  // read data valid the cycle after the strobe; serial bits are live status
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `ADDR_MEM_FLAGS:  rdata_o <= mem_flags;
        `ADDR_TMR_FLAGS:  rdata_o <= tmr_flags;
        `ADDR_PWM_FLAGS:  rdata_o <= pwm_flags;
        `ADDR_SER_FLAGS:  rdata_o <= {serial1_rx_not_empty_i,
                                      serial1_tx_empty_i,
                                      ser_flags[5:0]};
        `ADDR_IRQ_STATUS: rdata_o <= {4'h0, irq_status_ff};
        `ADDR_IRQ_MASK:   rdata_o <= {4'h0, irq_mask_ff};
        default:          rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule

/* rtl/sticky_flag_bank.v */
`timescale 1ns/1ps
`include "irq_flag_defs.vh"
// one 8-bit bank of hardware-set, write-to-clear-or-set flags
module sticky_flag_bank #(
  parameter [7:0] IMPL_MASK = 8'hFF
) (
  input  wire       core_clk_i,
  input  wire       rst_n_i,
  input  wire [7:0] set_i,
  input  wire       wr_i,
  input  wire [7:0] wdata_i,
  output wire [7:0] flags_o,
  output wire       rise_o
);
  reg  [7:0] flags_ff;
  reg  [7:0] nxt_flags;
  always @* begin
    // software writes the whole byte, but a same-cycle event still wins
    nxt_flags = wr_i ? wdata_i : flags_ff;
    nxt_flags = (nxt_flags | set_i) & IMPL_MASK;
  end
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      flags_ff <= `FLAGS_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end
  assign flags_o = flags_ff;
  assign rise_o  = |(set_i & IMPL_MASK & ~flags_ff);
endmodule

/* tb/irq_flag_props.sv */
`timescale 1ns/1ps
module irq_flag_props (
  input wire       core_clk_i,
  input wire       rst_n_i,
  input wire [7:0] addr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  input wire       timer_two_evt_i,
  input wire       timer_three_evt_i,
  input wire       pulse_unit1_period_evt_i,
  input wire [3:0] logic_cell_evt_i,
  input wire       serial1_rx_not_empty_i,
  input wire       serial1_tx_empty_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("stray read data");
  unmapped_rd_a: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rx_live_a: assert property (rd_i && addr_i == 8'h90 |=>
    rdata_o[7] == $past(serial1_rx_not_empty_i)) else $error("rx level wrong");
  tx_live_a: assert property (rd_i && addr_i == 8'h90 |=>
    rdata_o[6] == $past(serial1_tx_empty_i)) else $error("tx level wrong");
  timer_two_a: assert property (timer_two_evt_i ##1 rd_i && addr_i == 8'h8E |=>
    rdata_o[2]) else $error("timer two flag lost");
  timer_three_a: assert property (timer_three_evt_i ##1 rd_i && addr_i == 8'h8E |=>
    rdata_o[0]) else $error("timer three flag lost");
  pulse_period_a: assert property (pulse_unit1_period_evt_i ##1 rd_i && addr_i == 8'h8F
    |=> rdata_o[0]) else $error("period flag lost");
  cell_one_a: assert property (logic_cell_evt_i[0] ##1 rd_i && addr_i == 8'h90 |=>
    rdata_o[2]) else $error("logic cell flag lost");
endmodule
bind peripheral_irq_flag_regs irq_flag_props u_props (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .timer_two_evt_i(timer_two_evt_i), .timer_three_evt_i(timer_three_evt_i),
  .pulse_unit1_period_evt_i(pulse_unit1_period_evt_i), .logic_cell_evt_i(logic_cell_evt_i),
  .serial1_rx_not_empty_i(serial1_rx_not_empty_i), .serial1_tx_empty_i(serial1_tx_empty_i));

/* tb/periph_event_model.sv */
`timescale 1ns/1ps
// peripherals launch events from their own flops, so events lag the request by one cycle
module periph_event_model (
  input  wire        core_clk_i,
  input  wire [21:0] fire_i,
  output reg  [21:0] evt_o
);
  initial evt_o = 22'h100008;
  // events only set flags; serial levels follow buffer state, never a register write
  always @(posedge core_clk_i) begin
    evt_o <= fire_i;
  end
endmodule

/* tb/peripheral_irq_flag_regs_tb_top.sv */
`timescale 1ns/1ps
module peripheral_irq_flag_regs_tb_top;
  logic        core_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
  logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00, m, lv;
  logic [21:0] fire = 22'h100008, base = 22'h100008;
  wire  [21:0] ev;
  wire  [7:0]  rdata_o;
  wire         irq_o;
  logic [7:0]  exp_q[$];
  int          num_errors = 0, check_count = 0;
  logic [7:0]  ad[4] = '{8'h8D, 8'h8E, 8'h8F, 8'h90};
  logic [7:0]  msk[4] = '{8'h03, 8'h6F, 8'h0F, 8'h3F};
  int          sh[4] = '{0, 2, 10, 14};
  initial forever #12.5 core_clk_i = ~core_clk_i;
  periph_event_model u_model (.core_clk_i(core_clk_i), .fire_i(fire), .evt_o(ev));
  peripheral_irq_flag_regs u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .memory_op_done_evt_i(ev[0]), .checksum_evt_i(ev[1]), .timer_three_evt_i(ev[2]),
    .timer_three_gate_active_i(ev[3]), .timer_two_evt_i(ev[4]), .timer_four_evt_i(ev[5]),
    .capcmp_unit1_evt_i(ev[7]), .capcmp_unit2_evt_i(ev[8]),
    .pulse_unit1_period_evt_i(ev[10]), .pulse_unit1_param_evt_i(ev[11]),
    .pulse_unit2_period_evt_i(ev[12]), .pulse_unit2_param_evt_i(ev[13]),
    .oscillator_unit_evt_i(ev[14]), .waveform_gen_evt_i(ev[15]),
    .logic_cell_evt_i(ev[19:16]), .serial1_tx_empty_i(ev[20]),
    .serial1_rx_not_empty_i(ev[21]), .irq_o(irq_o));
  task chk(input logic [7:0] g, e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk_i);
    rd_i <= 1'b0;
  endtask
  // the gate input idles high, so xor with the base turns a requested gate bit into a fall
  task pulse(input logic [7:0] v, input int i);
    @(posedge core_clk_i);
    fire <= base ^ (22'(v) << sh[i]);
    @(posedge core_clk_i);
    fire <= base;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk_i) rd_d <= rd_i;
  always @(negedge core_clk_i) if (rd_d) chk(rdata_o, exp_q.pop_front());
  initial begin
    #50000;
    num_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h4A0E));
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(8'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      m = ($urandom | 8'h05) & msk[i];
      lv = (i == 3) ? 8'h40 : 8'h00;
      wr(ad[i], 8'h00);
      pulse(m, i);
      rd(ad[i], m | lv);
      wr(ad[i], 8'hFF);
      rd(ad[i], msk[i] | lv);
      wr(ad[i], 8'h00);
      rd(ad[i], lv);
      $display("flag bank %0d done", i);
    end
    wr(8'hA0, 8'h0F);
    wr(8'hA1, 8'h04);
    rd(8'hA1, 8'h04);
    pulse(8'h01, 0);
    rd(8'hA0, 8'h01);
    @(negedge core_clk_i);
    chk({7'h00, irq_o}, 8'h00);
    pulse(8'h01, 2);
    repeat (3) @(negedge core_clk_i);
    chk({7'h00, irq_o}, 8'h01);
    wr(8'hA0, 8'h04);
    @(negedge core_clk_i);
    chk({7'h00, irq_o}, 8'h00);
    $display("interrupt test done");
    @(posedge core_clk_i);
    base <= 22'h200008;
    fire <= 22'h200008;
    rd(8'h90, 8'h80);
    $display("serial level test done");
    repeat (3) @(posedge core_clk_i);
    end_sim();
  end
endmodule
